// file: core/phy_id_an_advert_regs.sv
// identifier and local auto-negotiation advertisement registers
`timescale 1ns/1ns
// Overview of operation
// - two read-only registers form a 32-bit identifier of org id, model, revision
// - a parameter can force all 32 identifier bits to read zero
// - first identifier register shows org id bits 3..18 in bits 15..0
// - second identifier register shows org id bits 19..24 in bits 15..10
// - six-bit model number in bits 9..4, msb at bit 9
// - four-bit revision in bits 3..0, msb at bit 3
// - bit 15 next page request, read/write, resets to 0
// - bit 14 ignores writes reads 0; bit 12 reserved reads 0
// - bit 13 remote fault advertise, read/write, resets to 0
// - bits 11 and 10 asymmetric and symmetric pause, read/write, reset 0
// - bit 9 four-pair ability fixed at 0
// - bits 8,7,6 read/write, reset from straps
// - bit 5 strap-reset read/write; bits 4..0 selector reset 00001
// - status bit 5 reads 1 once negotiation has completed
module phy_id_an_advert_regs
    import phy_id_an_pkg::*;
#(
    parameter logic identity_zero = 1'b0,         // forces identifier to zero
    parameter logic [21:0] org_id = 22'h15a5a5,   // arbitrary value, org id bits 3..24
    parameter logic [5:0] model_number = 6'h2a,   // arbitrary value
    parameter logic [3:0] revision = 4'h5         // arbitrary value
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [4:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic strap_fast_fd,
    input wire logic strap_fast,
    input wire logic strap_ten_fd,
    input wire logic strap_ten,
    input wire logic an_complete,
    output logic next_page_request,
    output logic remote_fault_advertise,
    output logic asymmetric_pause_advertise,
    output logic symmetric_pause_advertise,
    output logic fast_full_duplex_ability,
    output logic fast_ability,
    output logic ten_meg_full_duplex_ability,
    output logic ten_meg_ability,
    output logic [4:0] selector
);

    // synchroniser stages for the strap and completion pins
    logic [2:0] strap_meta_reg;
    logic [2:0] strap_sync_reg;
    logic strap10_meta_reg;
    logic strap10_sync_reg;
    logic an_meta_reg;
    logic an_sync_reg;

    // strap load strobe, high for the first cycle after reset release
    logic load_reg;

    // host write decode for the advertisement word
    logic adv_write_hit;

    // read images of the mapped registers
    logic [15:0] identifier_high;
    logic [15:0] identifier_low_model_rev;
    logic [15:0] autoneg_local_advertisement;
    logic [15:0] basic_status_register;

    // read mux result, captured on a read strobe
    logic [15:0] rdata_next;

    // strap pins pass two flip-flops before use
    always_ff @(posedge clk) begin
        strap_meta_reg <= {strap_fast_fd, strap_fast, strap_ten_fd};
        strap_sync_reg <= strap_meta_reg;
        strap10_meta_reg <= strap_ten;
        strap10_sync_reg <= strap10_meta_reg;
    end

    // completion pin passes two flip-flops before use
    always_ff @(posedge clk) begin
        an_meta_reg <= an_complete;
        an_sync_reg <= an_meta_reg;
    end

    // one-shot strap capture after reset release; straps settle during reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            load_reg <= 1'b1;
        end else begin
            load_reg <= 1'b0;
        end
    end

    // only the advertisement word takes writes; identifier writes fall through
    assign adv_write_hit = reg_write && (reg_addr == reg_advertisement_addr);

    // upper identifier word, org id bits 3..18
    assign identifier_high = identity_zero ? read_zero : org_id[21:6];

    // lower identifier word, org id bits 19..24, model, revision
    assign identifier_low_model_rev = identity_zero ? read_zero :
        {org_id[5:0], model_number, revision};

    // next page request flag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            next_page_request <= 1'b0;
        end else if (adv_write_hit) begin
            next_page_request <= reg_wdata[adv_next_page_bit];
        end
    end

    // remote fault advertise flag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            remote_fault_advertise <= 1'b0;
        end else if (adv_write_hit) begin
            remote_fault_advertise <= reg_wdata[adv_remote_fault_bit];
        end
    end

    // pause advertise flags for full-duplex flow control
    always_ff @(posedge clk) begin
        if (!rstn) begin
            asymmetric_pause_advertise <= 1'b0;
            symmetric_pause_advertise <= 1'b0;
        end else if (adv_write_hit) begin
            asymmetric_pause_advertise <= reg_wdata[adv_asym_pause_bit];
            symmetric_pause_advertise <= reg_wdata[adv_sym_pause_bit];
        end
    end

    // protocol selector field
    always_ff @(posedge clk) begin
        if (!rstn) begin
            selector <= selector_reset;
        end else if (adv_write_hit) begin
            selector <= reg_wdata[adv_selector_lsb +: 5];
        end
    end

    // strap-loaded duplex and fast ability bits; a write in the load cycle loses
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fast_full_duplex_ability <= 1'b0;
            fast_ability <= 1'b0;
            ten_meg_full_duplex_ability <= 1'b0;
        end else if (load_reg) begin
            fast_full_duplex_ability <= strap_sync_reg[2];
            fast_ability <= strap_sync_reg[1];
            ten_meg_full_duplex_ability <= strap_sync_reg[0];
        end else if (adv_write_hit) begin
            fast_full_duplex_ability <= reg_wdata[adv_fast_fd_bit];
            fast_ability <= reg_wdata[adv_fast_bit];
            ten_meg_full_duplex_ability <= reg_wdata[adv_ten_fd_bit];
        end
    end

    // strap-loaded 10 Mb/s ability bit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ten_meg_ability <= 1'b0;
        end else if (load_reg) begin
            ten_meg_ability <= strap10_sync_reg;
        end else if (adv_write_hit) begin
            ten_meg_ability <= reg_wdata[adv_ten_bit];
        end
    end

    // advertisement read image; bits 14, 12, 9 stay zero
    always_comb begin
        autoneg_local_advertisement = read_zero;
        autoneg_local_advertisement[adv_next_page_bit] = next_page_request;
        autoneg_local_advertisement[adv_reserved_ieee_bit] = 1'b0;
        autoneg_local_advertisement[adv_remote_fault_bit] = remote_fault_advertise;
        autoneg_local_advertisement[adv_reserved_future_bit] = 1'b0;
        autoneg_local_advertisement[adv_asym_pause_bit] = asymmetric_pause_advertise;
        autoneg_local_advertisement[adv_sym_pause_bit] = symmetric_pause_advertise;
        autoneg_local_advertisement[adv_four_pair_bit] = 1'b0;
        autoneg_local_advertisement[adv_fast_fd_bit] = fast_full_duplex_ability;
        autoneg_local_advertisement[adv_fast_bit] = fast_ability;
        autoneg_local_advertisement[adv_ten_fd_bit] = ten_meg_full_duplex_ability;
        autoneg_local_advertisement[adv_ten_bit] = ten_meg_ability;
        autoneg_local_advertisement[adv_selector_lsb +: 5] = selector;
    end

    // status read image, only the completion bit is implemented
    always_comb begin
        basic_status_register = read_zero;
        basic_status_register[status_an_complete_bit] = an_sync_reg;
    end

    // read mux, unmapped reads zero
    always_comb begin
        case (reg_addr)
            reg_basic_status_addr: rdata_next = basic_status_register;
            reg_identifier_high_addr: rdata_next = identifier_high;
            reg_identifier_low_addr: rdata_next = identifier_low_model_rev;
            reg_advertisement_addr: rdata_next = autoneg_local_advertisement;
            default: rdata_next = read_zero;
        endcase
    end

    // read answer strobe, one cycle after the read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
        end
    end

    // read data, held until the next read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= read_zero;
        end else if (reg_read) begin
            reg_rdata <= rdata_next;
        end
    end
endmodule // phy_id_an_advert_regs

// file: core/phy_id_an_pkg.sv
// constants for the identifier and advertisement register bank
package phy_id_an_pkg;
    localparam logic [4:0] reg_basic_status_addr = 5'h01;
    localparam logic [4:0] reg_identifier_high_addr = 5'h02;
    localparam logic [4:0] reg_identifier_low_addr = 5'h03;
    localparam logic [4:0] reg_advertisement_addr = 5'h04;
    // advertisement and status field positions
    localparam int adv_next_page_bit = 15;
    localparam int adv_reserved_ieee_bit = 14;
    localparam int adv_remote_fault_bit = 13;
    localparam int adv_reserved_future_bit = 12;
    localparam int adv_asym_pause_bit = 11;
    localparam int adv_sym_pause_bit = 10;
    localparam int adv_four_pair_bit = 9;
    localparam int adv_fast_fd_bit = 8;
    localparam int adv_fast_bit = 7;
    localparam int adv_ten_fd_bit = 6;
    localparam int adv_ten_bit = 5;
    localparam int adv_selector_lsb = 0;
    localparam int status_an_complete_bit = 5;
    // reset values
    localparam logic [4:0] selector_reset = 5'h01;
    localparam logic [15:0] read_zero = 16'h0000;
endpackage

// file: verif/mgmt_host.sv
// host model strobing the management registers
`timescale 1ns/1ns
module mgmt_host (
    input wire logic clk,
    input wire logic rv,
    input wire logic [15:0] rdat,
    output logic [4:0] a = 5'h00,
    output logic w = 1'b0,
    output logic r = 1'b0,
    output logic [15:0] wd = 16'h0000
);
    // bit 12 always sent as 0; write strobe held for one cycle
    task automatic wr(input logic [4:0] ad, input logic [15:0] d);
        @(posedge clk) #2 {a, wd, w} = {ad, d & 16'hefff, 1'b1};
        @(posedge clk) #2 {wd, w} = {~wd, 1'b0};
    endtask
    // one-cycle strobe, answer taken one edge later
    task automatic rd(input logic [4:0] ad, output logic [15:0] d, output logic ok);
        @(posedge clk) #2 {a, r} = {ad, 1'b1};
        @(posedge clk) #2 {d, ok, r} = {rdat, rv, 1'b0};
    endtask
endmodule // mgmt_host

// file: verif/phy_id_an_advert_regs_tb.sv
// self-checking bench for the identifier and advertisement bank
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin err_count++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module phy_id_an_advert_regs_tb;
    import phy_id_an_pkg::*;
    localparam logic [21:0] oid = 22'h2b3c4d; // arbitrary value
    logic clk = 1'b0, rstn = 1'b0, anc = 1'b0, ok, w, r, rv, np, rf, ap, sp, ffd, fa, tfd, ten;
    logic [3:0] strap;
    logic [4:0] a, sel;
    logic [15:0] wd, rdat, rdz, d, x;
    // reference image of the bank kept from the rules, and the reads in flight
    logic [15:0] model [0:31];
    logic [15:0] exp_q [$];
    int err_count = 0, tests_run = 0;
    int unsigned seed = 10;
    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    mgmt_host u_host (.clk(clk), .rv(rv), .rdat(rdat), .a(a), .w(w), .r(r), .wd(wd));
    phy_id_an_advert_regs #(.org_id(oid), .model_number(6'h1c), .revision(4'h9)) u_dut (.clk(clk), .rstn(rstn),
        .reg_addr(a), .reg_write(w), .reg_read(r), .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv),
        .strap_fast_fd(strap[3]), .strap_fast(strap[2]), .strap_ten_fd(strap[1]), .strap_ten(strap[0]),
        .an_complete(anc), .next_page_request(np), .remote_fault_advertise(rf), .asymmetric_pause_advertise(ap),
        .symmetric_pause_advertise(sp), .fast_full_duplex_ability(ffd), .fast_ability(fa),
        .ten_meg_full_duplex_ability(tfd), .ten_meg_ability(ten), .selector(sel));
    // second bank on the same bus with the identifier forced to zero
    phy_id_an_advert_regs #(.identity_zero(1'b1), .org_id(oid), .model_number(6'h1c), .revision(4'h9)) u_dut_zero (
        .clk(clk), .rstn(rstn), .reg_addr(a), .reg_write(w), .reg_read(r), .reg_wdata(wd), .reg_rdata(rdz),
        .reg_rvalid(), .strap_fast_fd(strap[3]), .strap_fast(strap[2]), .strap_ten_fd(strap[1]),
        .strap_ten(strap[0]), .an_complete(anc), .next_page_request(), .remote_fault_advertise(),
        .asymmetric_pause_advertise(), .symmetric_pause_advertise(), .fast_full_duplex_ability(),
        .fast_ability(), .ten_meg_full_duplex_ability(), .ten_meg_ability(), .selector());
    // host write mirrored into the model; only the advertisement word takes it
    task automatic mwr(input logic [4:0] ad, input logic [15:0] v);
        u_host.wr(ad, v);
        if (ad == reg_advertisement_addr) model[ad] = v & 16'hadff;
    endtask
    task automatic summarize();
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // read with bounded answer, then compare
    task automatic chk(input logic [4:0] ad, input logic [15:0] e, input string n);
        logic [15:0] m;
        exp_q.push_back(model[ad]);
        u_host.rd(ad, d, ok);
        m = exp_q.pop_front();
        if (ok !== 1'b1) begin err_count++; summarize(); end
        `CHK(n, e, d)
        `CHK(n, m, d)
    endtask
    initial forever #25 clk = ~clk;
    // reset, identity, refusals, random advertisement traffic, status
    initial begin
        x = xs();
        strap = x[3:0];
        for (int i = 0; i < 32; i++) model[i] = 16'h0000;
        model[reg_identifier_high_addr] = oid[21:6];
        model[reg_identifier_low_addr] = {oid[5:0], 6'h1c, 4'h9};
        model[reg_advertisement_addr] = {7'h00, strap, selector_reset};
        repeat (8) @(posedge clk);
        #2 rstn = 1'b1;
        repeat (2) @(posedge clk);
        chk(5'h02, oid[21:6], "id_high");
        `CHK("id_high_zero", 16'h0000, rdz)
        chk(5'h03, {oid[5:0], 6'h1c, 4'h9}, "id_low");
        `CHK("id_low_zero", 16'h0000, rdz)
        chk(5'h04, {7'h00, strap, selector_reset}, "adv_reset");
        mwr(5'h02, 16'hffff);
        mwr(5'h03, 16'hffff);
        mwr(5'h01, 16'hffff);
        chk(5'h02, oid[21:6], "id_high");
        chk(5'h03, {oid[5:0], 6'h1c, 4'h9}, "id_low");
        chk(5'h04, {7'h00, strap, selector_reset}, "adv_kept");
        chk(5'h05, 16'h0000, "unmapped");
        mwr(5'h04, 16'hffff);
        chk(5'h04, 16'hadff, "adv_ones");
        repeat (20) begin
            x = xs();
            mwr(5'h04, x);
            chk(5'h04, x & 16'hadff, "adv");
            `CHK("adv_pins", x & 16'hadff, {np, 1'b0, rf, 1'b0, ap, sp, 1'b0, ffd, fa, tfd, ten, sel})
        end
        anc = 1'b1;
        model[reg_basic_status_addr] = 16'h0020;
        repeat (4) @(posedge clk);
        chk(5'h01, 16'h0020, "status");
        anc = 1'b0;
        model[reg_basic_status_addr] = 16'h0000;
        repeat (4) @(posedge clk);
        chk(5'h01, 16'h0000, "status");
        summarize();
    end
endmodule // phy_id_an_advert_regs_tb

// file: verif/phy_id_an_sva.sv
// bound assertions for the identifier and advertisement bank
`timescale 1ns/1ns
module phy_id_an_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic reg_rvalid,
    input wire logic [4:0] reg_addr,
    input wire logic [4:0] selector,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic next_page_request,
    input wire logic remote_fault_advertise,
    input wire logic asymmetric_pause_advertise,
    input wire logic symmetric_pause_advertise,
    input wire logic fast_full_duplex_ability,
    input wire logic fast_ability,
    input wire logic ten_meg_full_duplex_ability,
    input wire logic ten_meg_ability
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // advertisement fields as the register should read
    wire logic [15:0] adv = {next_page_request, 1'b0, remote_fault_advertise, 1'b0, asymmetric_pause_advertise,
        symmetric_pause_advertise, 1'b0, fast_full_duplex_ability, fast_ability, ten_meg_full_duplex_ability,
        ten_meg_ability, selector};
    sequence s_adv_wr;
        reg_write && reg_addr == 5'h04 && $past(rstn);
    endsequence
    a_rvalid_after_read: assert property (reg_read |=> reg_rvalid) else $error("no read answer");
    a_no_stray_valid: assert property (!reg_read |=> !reg_rvalid) else $error("stray rvalid");
    a_adv_read_mirror: assert property (reg_read && reg_addr == 5'h04 && !reg_write |=> reg_rdata == adv)
        else $error("adv read differs");
    a_status_zero_bits: assert property (reg_read && reg_addr == 5'h01 |=> (reg_rdata & 16'hffdf) == 16'h0000)
        else $error("status bits set");
    a_adv_write_lands: assert property (s_adv_wr |=> adv[15] == $past(reg_wdata[15])
        && adv[13:5] == ($past(reg_wdata[13:5]) & 9'h16f)
        && selector == $past(reg_wdata[4:0])) else $error("write lost");
    a_id_write_ignored: assert property (reg_write && reg_addr inside {5'h01, 5'h02, 5'h03} && $past(rstn)
        |=> $stable(adv)) else $error("id write changed adv");
    a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata)) else $error("rdata moved");
    a_idle_adv_stable: assert property (!reg_write && $past(rstn) |=> $stable(adv)) else $error("adv moved");
endmodule // phy_id_an_sva
bind phy_id_an_advert_regs phy_id_an_sva u_sva (.*);
